//--- shared/pcc_cal_regs.vh
/*
 Constants for the phase-position and current-sense calibration command registers:
 command codes, field positions, reset values, range limits and the transfer length.
 Assumes inclusion by bare name from the design files; holds definitions only.
*/
`ifndef PCC_CAL_REGS_VH
`define PCC_CAL_REGS_VH

// Command codes
`define PCC_CMD_PHASE_POSITION      8'h37
`define PCC_CMD_SENSE_GAIN          8'h38
`define PCC_CMD_SENSE_OFFSET        8'h39

// Field layout
`define PCC_POS_MSB                 3
`define PCC_POS_LSB                 0
`define PCC_L11_EXP_MSB             15
`define PCC_L11_EXP_LSB             11
`define PCC_L11_MANT_MSB            10
`define PCC_L11_MANT_LSB            0

// Reset values
`define PCC_SENSE_GAIN_RESET        16'hAA66
`define PCC_SENSE_OFFSET_RESET      16'h0000

// Position zero stands for the last slot of the group
`define PCC_POS_ZERO_MEANS          5'h10
// Phase step in tenths of a degree (22.5 degrees)
`define PCC_PHASE_STEP_TENTHS       12'h0E1

// Range limits: gain in milliohms, offset in amperes
`define PCC_GAIN_LIMIT_MOHM         32'h000003E8
`define PCC_OFFSET_LIMIT_AMP        32'h0000000A

// Only word transfers reach the calibration registers
`define PCC_WORD_BYTES              3'h2

`endif

//--- verilog/pcc_l11_range.v
/*
 Linear-11 range check: decodes a word as mantissa times two to the exponent and
 reports its sign and whether its magnitude lies within LIMIT (inclusive).
 Assumes a purely combinational use by the command register block.
*/
`timescale 1ns/10ps
`include "pcc_cal_regs.vh"

module pcc_l11_range
#(
	parameter [31:0] LIMIT = 32'h0000000A
)
(
	input  wire [15:0] word,
	output wire        isPositive,
	output wire        isNegative,
	output wire        withinLimit
);

	wire signed [4:0]  expo;
	wire signed [10:0] mant;
	wire        [11:0] mag;
	wire        [4:0]  negExp;
	reg         [31:0] lhs;
	reg         [31:0] rhs;

	// Exponent and mantissa are both two's complement
	assign expo       = word[`PCC_L11_EXP_MSB:`PCC_L11_EXP_LSB];
	assign mant       = word[`PCC_L11_MANT_MSB:`PCC_L11_MANT_LSB];
	assign mag        = mant[10] ? (12'h000 - {mant[10], mant}) : {1'b0, mant};
	assign negExp     = 5'h00 - expo;
	assign isPositive = !mant[10] && (mant != 11'h000);
	assign isNegative = mant[10];

	// Shift whichever side keeps the compare exact: no bits of the mantissa are lost
	always @*
	begin
		if (!expo[4])
		begin
			lhs = {20'h00000, mag} << expo[3:0];
			rhs = LIMIT;
		end
		else
		begin
			lhs = {20'h00000, mag};
			rhs = LIMIT << negExp;
		end
	end

	assign withinLimit = (lhs <= rhs);

endmodule

//--- verilog/pcc_cal_regs.v
/*
 Command registers for phase position, current-sense gain and current-sense offset.
 Reached by command code from the bus protocol engine, which hands over one decoded
 command per strobe with its byte count. The bus address pins arrive from outside
 the clock domain. Decoded calibration fields feed the current telemetry and the
 sense blanking compensation, which live elsewhere.
*/
`timescale 1ns/10ps
`include "pcc_cal_regs.vh"

module pcc_cal_regs
(
	input  wire        mclk,
	input  wire        rstn,
	input  wire [3:0]  busAddrLow,
	input  wire        cmdStrobe,
	input  wire        cmdWrite,
	input  wire [7:0]  cmdCode,
	input  wire [2:0]  cmdByteCount,
	input  wire [15:0] cmdWdata,
	output reg         cmdAck,
	output reg         cmdNack,
	output reg  [15:0] cmdRdata,
	output reg  [4:0]  phasePosition,
	output reg  [11:0] phaseOffsetTenths,
	output reg  [4:0]  senseGainExp,
	output reg  [10:0] senseGainMant,
	output reg  [4:0]  senseOffsetExp,
	output reg  [10:0] senseOffsetMant,
	output reg         calUpdated
);

	reg  [3:0]  addrSync1_q;
	reg  [3:0]  addrSync2_q;
	reg  [3:0]  addrSync3_q;
	reg  [3:0]  addrStable_q;
	reg  [3:0]  posField_q;
	reg         posWritten_q;
	reg  [15:0] senseGain_q;
	reg  [15:0] senseOffset_q;
	wire [3:0]  posEffective;
	wire [4:0]  posSlot_d;
	wire        gainPositive;
	wire        gainWithin;
	wire        offsetWithin;
	wire        isPos;
	wire        isGain;
	wire        isOffset;
	wire        mapped;
	wire        lenOk;
	wire        gainOk;
	wire        offsetOk;
	reg         accept_d;
	reg  [15:0] rdata_d;

	pcc_l11_range
	#(
		.LIMIT(`PCC_GAIN_LIMIT_MOHM)
	)
	u_gainRange
	(
		.word        (cmdWdata),
		.isPositive  (gainPositive),
		.isNegative  (),
		.withinLimit (gainWithin)
	);

	pcc_l11_range
	#(
		.LIMIT(`PCC_OFFSET_LIMIT_AMP)
	)
	u_offsetRange
	(
		.word        (cmdWdata),
		.isPositive  (),
		.isNegative  (),
		.withinLimit (offsetWithin)
	);

	// Address straps come off pins; a change is taken only once stages two and three agree
	genvar i;
	generate
		for (i = 0; i < 4; i = i + 1)
		begin : gAddrSync
			always @(posedge mclk or negedge rstn)
			begin
				if (!rstn)
				begin
					addrSync1_q[i]  <= 1'b0;
					addrSync2_q[i]  <= 1'b0;
					addrSync3_q[i]  <= 1'b0;
					addrStable_q[i] <= 1'b0;
				end
				else
				begin
					addrSync1_q[i] <= busAddrLow[i];
					addrSync2_q[i] <= addrSync1_q[i];
					addrSync3_q[i] <= addrSync2_q[i];
					if (addrSync2_q[i] == addrSync3_q[i])
						addrStable_q[i] <= addrSync3_q[i];
				end
			end
		end
	endgenerate

	// Address default stays live until software takes over the field
	assign posEffective = posWritten_q ? posField_q : addrStable_q;
	assign posSlot_d    = (posEffective == 4'h0) ? `PCC_POS_ZERO_MEANS : {1'b0, posEffective};

	assign isPos    = (cmdCode == `PCC_CMD_PHASE_POSITION);
	assign isGain   = (cmdCode == `PCC_CMD_SENSE_GAIN);
	assign isOffset = (cmdCode == `PCC_CMD_SENSE_OFFSET);
	assign mapped   = isPos | isGain | isOffset;
	assign lenOk    = (cmdByteCount == `PCC_WORD_BYTES);
	assign gainOk   = gainPositive && gainWithin;
	assign offsetOk = offsetWithin;

	// Decide the answer and the read word for the command now on the port
	always @*
	begin
		accept_d = 1'b0;
		rdata_d  = 16'h0000;
		if (mapped && lenOk)
		begin
			if (!cmdWrite)
			begin
				accept_d = 1'b1;
				if (isPos)
					rdata_d = {12'h000, posEffective};
				else if (isGain)
					rdata_d = senseGain_q;
				else
					rdata_d = senseOffset_q;
			end
			else if (isPos)
				accept_d = 1'b1;
			else if (isGain)
				accept_d = gainOk;
			else
				accept_d = offsetOk;
		end
	end

	// Register storage; a refused write leaves the old value untouched
	always @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			posField_q    <= 4'h0;
			posWritten_q  <= 1'b0;
			senseGain_q   <= `PCC_SENSE_GAIN_RESET;
			senseOffset_q <= `PCC_SENSE_OFFSET_RESET;
		end
		else if (cmdStrobe && cmdWrite && accept_d)
		begin
			if (isPos)
			begin
				posField_q   <= cmdWdata[`PCC_POS_MSB:`PCC_POS_LSB];
				posWritten_q <= 1'b1;
			end
			if (isGain)
				senseGain_q <= cmdWdata;
			if (isOffset)
				senseOffset_q <= cmdWdata;
		end
	end

	// Answer one cycle after the strobe; a read of an unknown code or wrong length is refused
	always @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			cmdAck     <= 1'b0;
			cmdNack    <= 1'b0;
			cmdRdata   <= 16'h0000;
			calUpdated <= 1'b0;
		end
		else
		begin
			cmdAck     <= cmdStrobe && accept_d;
			cmdNack    <= cmdStrobe && !accept_d;
			calUpdated <= cmdStrobe && cmdWrite && accept_d && (isGain || isOffset);
			if (cmdStrobe && !cmdWrite && accept_d)
				cmdRdata <= rdata_d;
		end
	end

	// Decoded settings for the phase generator and the current telemetry
	always @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			phasePosition     <= `PCC_POS_ZERO_MEANS;
			phaseOffsetTenths <= 12'h000;
			senseGainExp      <= 5'h00;
			senseGainMant     <= 11'h000;
			senseOffsetExp    <= 5'h00;
			senseOffsetMant   <= 11'h000;
		end
		else
		begin
			phasePosition     <= posSlot_d;
			// Slot sixteen lands on 360 degrees, the same as the sync edge itself
			phaseOffsetTenths <= {7'h00, posSlot_d} * `PCC_PHASE_STEP_TENTHS;
			senseGainExp      <= senseGain_q[`PCC_L11_EXP_MSB:`PCC_L11_EXP_LSB];
			senseGainMant     <= senseGain_q[`PCC_L11_MANT_MSB:`PCC_L11_MANT_LSB];
			// The same offset serves static nulling and blanking-delay correction
			senseOffsetExp    <= senseOffset_q[`PCC_L11_EXP_MSB:`PCC_L11_EXP_LSB];
			senseOffsetMant   <= senseOffset_q[`PCC_L11_MANT_MSB:`PCC_L11_MANT_LSB];
		end
	end

endmodule

//--- verif/pcc_cal_checker.sv
/*
 Port checker for the calibration command registers.
 Assumes bind onto pcc_cal_regs, mclk rising edge, rstn async active low.
*/
`timescale 1ns/10ps
module pcc_cal_checker
(
	input wire logic        mclk,
	input wire logic        rstn,
	input wire logic        cmdStrobe,
	input wire logic        cmdWrite,
	input wire logic [7:0]  cmdCode,
	input wire logic [2:0]  cmdByteCount,
	input wire logic        cmdAck,
	input wire logic        cmdNack,
	input wire logic        calUpdated,
	input wire logic [4:0]  phasePosition,
	input wire logic [11:0] phaseOffsetTenths
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	a_len_refused: assert property (cmdStrobe && cmdByteCount != 3'h2 |=> cmdNack) else $error("bad length taken");
	a_one_answer: assert property (cmdStrobe |=> cmdAck != cmdNack) else $error("answer missing");
	a_no_spurious: assert property (!$past(cmdStrobe) |-> !cmdAck && !cmdNack) else $error("answer unasked");
	a_pos_taken: assert property (cmdStrobe && cmdWrite && cmdCode == 8'h37 && cmdByteCount == 3'h2
		|=> cmdAck) else $error("position write refused");
	a_pos_range: assert property (phasePosition != 5'h00 && phasePosition <= 5'h10) else $error("slot range");
	// Settled slot only: right after reset the offset reads zero while the slot shows sixteen
	a_phase_step: assert property ($stable(phasePosition)[*3] |->
		phaseOffsetTenths == 12'(phasePosition) * 12'h0E1) else $error("phase step");
	a_upd_cause: assert property (calUpdated |-> cmdAck && $past(cmdWrite) &&
		($past(cmdCode) == 8'h38 || $past(cmdCode) == 8'h39)) else $error("stray update");
	a_read_quiet: assert property (cmdStrobe && !cmdWrite |=> !calUpdated) else $error("read updated");
endmodule
bind pcc_cal_regs pcc_cal_checker u_chk (.mclk, .rstn, .cmdStrobe, .cmdWrite, .cmdCode, .cmdByteCount,
	.cmdAck, .cmdNack, .calUpdated, .phasePosition, .phaseOffsetTenths);

//--- verif/pcc_host_model.sv
/*
 Host side model: issues one decoded command per call and returns the answer.
 Assumes answers come one cycle after the strobe edge.
*/
`timescale 1ns/10ps
module pcc_host_model
(
	input wire logic        mclk,
	input wire logic        cmdAck,
	input wire logic        cmdNack,
	input wire logic [15:0] cmdRdata,
	output logic            cmdStrobe,
	output logic            cmdWrite,
	output logic [7:0]      cmdCode,
	output logic [2:0]      cmdByteCount,
	output logic [15:0]     cmdWdata
);
	initial
	begin
		cmdStrobe = 1'b0;
		cmdWrite = 1'b0;
		cmdCode = 8'h00;
		cmdByteCount = 3'h2;
		cmdWdata = 16'h0000;
	end
	task automatic xfer(input logic w, input logic [7:0] c, input logic [2:0] n, input logic [15:0] d,
		output logic [1:0] an, output logic [15:0] r);
		@(posedge mclk);
		cmdStrobe <= 1'b1;
		cmdWrite <= w;
		cmdCode <= c;
		cmdByteCount <= n;
		cmdWdata <= d;
		@(posedge mclk);
		cmdStrobe <= 1'b0;
		// Released data shows the inverse so stale words are never mistaken for live ones
		cmdWdata <= ~d;
		@(negedge mclk);
		an = {cmdAck, cmdNack};
		r = cmdRdata;
	endtask
endmodule

//--- verif/tb_top.sv
/*
 Testbench for pcc_cal_regs: command sequences with expected answers.
 Assumes a 40 MHz mclk and the host model beside the design.
*/
`timescale 1ns/10ps
module tb_top;
	logic        mclk, rstn, cmdStrobe, cmdWrite, cmdAck, cmdNack, calUpdated;
	logic [3:0]  busAddrLow;
	logic [7:0]  cmdCode;
	logic [2:0]  cmdByteCount;
	logic [15:0] cmdWdata, cmdRdata, rd;
	logic [4:0]  phasePosition, senseGainExp, senseOffsetExp;
	logic [11:0] phaseOffsetTenths;
	logic [10:0] senseGainMant, senseOffsetMant;
	logic [1:0]  an;
	logic [15:0] expReg[2] = '{16'hAA66, 16'h0000};
	logic [7:0]  tc[11] = '{8'h38, 8'h38, 8'h38, 8'h38, 8'h38, 8'h39, 8'h39, 8'h39, 8'h39, 8'h39, 8'h39};
	logic [15:0] td[11] = '{16'h03E8, 16'h03E9, 16'h0000, 16'h07FF, 16'hF801,
		16'h000A, 16'h000B, 16'h07F6, 16'h07F5, 16'h0805, 16'h0806};
	logic        ta[11] = '{1, 0, 0, 0, 1, 1, 0, 1, 0, 1, 0};
	int          fails = 0, samplesChecked = 0;
	pcc_cal_regs dut
	(
		.mclk              (mclk),
		.rstn              (rstn),
		.busAddrLow        (busAddrLow),
		.cmdStrobe         (cmdStrobe),
		.cmdWrite          (cmdWrite),
		.cmdCode           (cmdCode),
		.cmdByteCount      (cmdByteCount),
		.cmdWdata          (cmdWdata),
		.cmdAck            (cmdAck),
		.cmdNack           (cmdNack),
		.cmdRdata          (cmdRdata),
		.phasePosition     (phasePosition),
		.phaseOffsetTenths (phaseOffsetTenths),
		.senseGainExp      (senseGainExp),
		.senseGainMant     (senseGainMant),
		.senseOffsetExp    (senseOffsetExp),
		.senseOffsetMant   (senseOffsetMant),
		.calUpdated        (calUpdated)
	);
	pcc_host_model host
	(
		.mclk         (mclk),
		.cmdAck       (cmdAck),
		.cmdNack      (cmdNack),
		.cmdRdata     (cmdRdata),
		.cmdStrobe    (cmdStrobe),
		.cmdWrite     (cmdWrite),
		.cmdCode      (cmdCode),
		.cmdByteCount (cmdByteCount),
		.cmdWdata     (cmdWdata)
	);
	initial
	begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	task chk(input logic [15:0] s, input logic [15:0] e);
		samplesChecked++;
		if (s !== e)
		begin
			fails++;
			$display("ERROR %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task xf(input logic w, input logic [7:0] c, input logic [2:0] n, input logic [15:0] d, input logic ok);
		host.xfer(w, c, n, d, an, rd);
		chk({14'h0, an}, ok ? 16'h0002 : 16'h0001);
		chk({15'h0, calUpdated}, {15'h0, w && ok && (c != 8'h37)});
	endtask
	task report_and_stop;
		$display("checks %0d mismatches %0d", samplesChecked, fails);
		if (fails == 0 && samplesChecked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task settle;
		repeat (8) @(posedge mclk);
		#1;
	endtask
	initial
	begin
		#50000;
		fails++;
		report_and_stop;
	end
	initial
	begin
		rstn = 1'b0;
		busAddrLow = 4'h5;
		repeat (3) @(posedge mclk);
		rstn <= 1'b1;
		xf(0, 8'h38, 3'h2, 16'h0, 1);
		chk(rd, 16'hAA66);
		xf(0, 8'h39, 3'h2, 16'h0, 1);
		chk(rd, 16'h0000);
		chk({senseGainExp, senseGainMant}, 16'hAA66);
		settle;
		chk({11'h0, phasePosition}, 16'h0005);
		chk({4'h0, phaseOffsetTenths}, 16'h0465);
		@(posedge mclk);
		busAddrLow <= 4'h0;
		settle;
		chk({11'h0, phasePosition}, 16'h0010);
		xf(1, 8'h37, 3'h2, 16'hFFF3, 1);
		xf(0, 8'h37, 3'h2, 16'h0, 1);
		chk(rd, 16'h0003);
		@(posedge mclk);
		busAddrLow <= 4'h9;
		settle;
		chk({11'h0, phasePosition}, 16'h0003);
		chk({4'h0, phaseOffsetTenths}, 16'h02A3);
		xf(1, 8'h37, 3'h2, 16'h0000, 1);
		settle;
		chk({11'h0, phasePosition}, 16'h0010);
		chk({4'h0, phaseOffsetTenths}, 16'h0E10);
		for (int i = 0; i < 11; i++)
		begin
			xf(1, tc[i], 3'h2, td[i], ta[i]);
			if (ta[i])
				expReg[tc[i] - 8'h38] = td[i];
			xf(0, tc[i], 3'h2, 16'h0, 1);
			chk(rd, expReg[tc[i] - 8'h38]);
		end
		settle;
		chk({senseGainExp, senseGainMant}, expReg[0]);
		chk({senseOffsetExp, senseOffsetMant}, expReg[1]);
		xf(0, 8'h38, 3'h1, 16'h0, 0);
		xf(1, 8'h39, 3'h3, 16'h0001, 0);
		xf(1, 8'h3A, 3'h2, 16'h0, 0);
		xf(0, 8'h39, 3'h2, 16'h0, 1);
		chk(rd, expReg[1]);
		// Reset in mid-run must restore defaults and hand the slot back to the address straps
		@(posedge mclk);
		rstn <= 1'b0;
		repeat (3) @(posedge mclk);
		rstn <= 1'b1;
		xf(0, 8'h38, 3'h2, 16'h0, 1);
		chk(rd, 16'hAA66);
		xf(0, 8'h39, 3'h2, 16'h0, 1);
		chk(rd, 16'h0000);
		settle;
		chk({11'h0, phasePosition}, 16'h0009);
		chk({4'h0, phaseOffsetTenths}, 16'h07E9);
		chk({senseGainExp, senseGainMant}, 16'hAA66);
		chk({senseOffsetExp, senseOffsetMant}, 16'h0000);
		report_and_stop;
	end
endmodule
